// ==== hw/dsai_regs.svh ====
`ifndef DSAI_REGS_SVH
`define DSAI_REGS_SVH

// register indices, byte address is four times the index
`define DSAI_IDX_FLAGS_A   8'h27
`define DSAI_IDX_FLAGS_B   8'h28
`define DSAI_IDX_FLAGS_C   8'h29
`define DSAI_IDX_MASK_A    8'h30
`define DSAI_IDX_MASK_B    8'h31
`define DSAI_IDX_MASK_C    8'h32
`define DSAI_IDX_EDGE      8'h3f
`define DSAI_ADDR_W        10

// edge select fields and reset values
`define DSAI_EDGE_RISE_BIT 1
`define DSAI_EDGE_FALL_BIT 0
`define DSAI_EDGE_RST      2'h2
`define DSAI_MASK_RST      24'h000000

// flag positions in the 24-bit flag vector
`define DSAI_NEW_BIT       7
`define DSAI_SEF_BIT       15

// message repeat and errored-frame window
`define DSAI_FEAC_REPEAT   3'h5
`define DSAI_SEF_WIN       16
`define DSAI_SEF_THRESH    3

`define DSAI_RESP_OKAY     2'h0
`define DSAI_RESP_SLVERR   2'h2

`endif

// ==== hw/dsai_pkg.sv ====
`default_nettype none
package dsai_pkg;

   // live source conditions sampled for edge detection
   typedef struct packed {
      logic [7:0] rx_status;
      logic [6:0] lb_b;
      logic [6:0] lb_a;
   } dsai_src_t;

   // one received far-end alarm message code
   typedef struct packed {
      logic       valid;
      logic [5:0] code;
   } dsai_feac_t;

   // one received framing bit result
   typedef struct packed {
      logic valid;
      logic err;
      logic in_frame;
   } dsai_fbit_t;

   typedef logic [23:0] dsai_flags_t;

endpackage
`default_nettype wire

// ==== hw/dsai_sef_det.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsai_regs.svh"

module dsai_sef_det #(
   parameter int WIN = `DSAI_SEF_WIN
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire dsai_pkg::dsai_fbit_t fbit,
   output logic                   sef
);

   localparam int CW = $clog2(WIN + 1);
   localparam logic [CW-1:0] THRESH = CW'(`DSAI_SEF_THRESH);

   logic [WIN-1:0] hist;
   logic [CW-1:0]  err_cnt;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hist <= '0;
      else if (fbit.valid)
         hist <= {hist[WIN-2:0], fbit.err};
   end

   always_comb
   begin
      err_cnt = '0;
      for (int i = 0; i < WIN; i++)
         err_cnt = err_cnt + CW'(hist[i]);
   end

   // hold the defect until framing recovers and the window error count is below the threshold
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sef <= 1'b0;
      else if (err_cnt >= THRESH)
         sef <= 1'b1;
      else if (fbit.in_frame)
         sef <= 1'b0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sef_entry_a: assert property (err_cnt >= THRESH |=> sef)
      else $error("errored frame not declared at threshold");
   sef_exit_a: assert property (sef && fbit.in_frame && err_cnt < THRESH |=> !sef)
      else $error("errored frame defect not ended");

endmodule
`default_nettype wire

// ==== hw/dsai_irq_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsai_regs.svh"

module dsai_irq_flags (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [`DSAI_ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [`DSAI_ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire dsai_pkg::dsai_src_t          src,
   input  wire dsai_pkg::dsai_feac_t         feac,
   input  wire dsai_pkg::dsai_fbit_t         fbit,
   output logic                              irq
);

   dsai_pkg::dsai_flags_t flags;
   dsai_pkg::dsai_flags_t mask;
   dsai_pkg::dsai_flags_t cur;
   dsai_pkg::dsai_flags_t prev;
   dsai_pkg::dsai_flags_t set_v;
   dsai_pkg::dsai_flags_t rd_clr;
   dsai_pkg::dsai_flags_t wr_clr;
   logic [1:0]            edge_sel;
   logic                  rise_en;
   logic                  fall_en;
   logic [5:0]            last_code;
   logic [2:0]            rep_cnt;
   logic                  new_cond;
   logic                  sef;
   logic                  wr_go;
   logic                  rd_go;
   logic [7:0]            wr_idx;
   logic [7:0]            rd_idx;

   assign rise_en = edge_sel[`DSAI_EDGE_RISE_BIT];
   assign fall_en = edge_sel[`DSAI_EDGE_FALL_BIT];

   // ---------------- far-end message repeat detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         last_code <= 6'h00;
         rep_cnt   <= 3'h0;
      end
      else if (feac.valid)
      begin
         last_code <= feac.code;
         // saturate so a steady repeat is declared only once
         if (feac.code == last_code && rep_cnt != 3'h0)
         begin
            if (rep_cnt != `DSAI_FEAC_REPEAT)
               rep_cnt <= rep_cnt + 3'h1;
         end
         else
            rep_cnt <= 3'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         new_cond <= 1'b0;
      else
         new_cond <= feac.valid && feac.code == last_code
                     && rep_cnt == `DSAI_FEAC_REPEAT - 3'h1;
   end

   // ---------------- errored frame detector
   // sliding window detector
   dsai_sef_det #(
      .WIN (`DSAI_SEF_WIN)
   ) u_sef (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fbit    (fbit),
      .sef     (sef)
   );

   // ---------------- condition edges and flags
   // per-register flag layout
   assign cur = {src.rx_status, sef, src.lb_b, new_cond, src.lb_a};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prev <= '0;
      else
         prev <= cur;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 24; gi++)
      begin : g_flag
         if (gi == `DSAI_SEF_BIT)
         begin : g_entry
            assign set_v[gi] = cur[gi] & ~prev[gi];
         end
         else
         begin : g_edge
            assign set_v[gi] = (rise_en & cur[gi] & ~prev[gi])
                             | (fall_en & ~cur[gi] & prev[gi]);
         end

         // clear on read, a new event wins over the clear
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               flags[gi] <= 1'b0;
            else
               flags[gi] <= set_v[gi] | (flags[gi] & ~rd_clr[gi] & ~wr_clr[gi]);
         end
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(flags & mask);
   end

   // ---------------- AXI4-Lite write channel
   // address and data are taken together; a lone channel simply waits
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign wr_idx        = s_axi_awaddr[`DSAI_ADDR_W-1:2];

   always_comb
   begin
      wr_clr = '0;
      if (wr_go && s_axi_wstrb[0])
      begin
         unique case (wr_idx)
            `DSAI_IDX_FLAGS_A: wr_clr[7:0]   = s_axi_wdata[7:0];
            `DSAI_IDX_FLAGS_B: wr_clr[15:8]  = s_axi_wdata[7:0];
            `DSAI_IDX_FLAGS_C: wr_clr[23:16] = s_axi_wdata[7:0];
            default:           wr_clr        = '0;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mask     <= `DSAI_MASK_RST;
         edge_sel <= `DSAI_EDGE_RST;
      end
      else if (wr_go && s_axi_wstrb[0])
      begin
         unique case (wr_idx)
            `DSAI_IDX_MASK_A: mask[7:0]   <= s_axi_wdata[7:0];
            `DSAI_IDX_MASK_B: mask[15:8]  <= s_axi_wdata[7:0];
            `DSAI_IDX_MASK_C: mask[23:16] <= s_axi_wdata[7:0];
            `DSAI_IDX_EDGE:   edge_sel    <= s_axi_wdata[1:0];
            default:          edge_sel    <= edge_sel;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DSAI_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         unique case (wr_idx)
            `DSAI_IDX_FLAGS_A, `DSAI_IDX_FLAGS_B, `DSAI_IDX_FLAGS_C,
            `DSAI_IDX_MASK_A, `DSAI_IDX_MASK_B, `DSAI_IDX_MASK_C,
            `DSAI_IDX_EDGE: s_axi_bresp <= `DSAI_RESP_OKAY;
            default:        s_axi_bresp <= `DSAI_RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ---------------- AXI4-Lite read channel
   assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_idx        = s_axi_araddr[`DSAI_ADDR_W-1:2];

   always_comb
   begin
      rd_clr = '0;
      if (rd_go)
      begin
         unique case (rd_idx)
            `DSAI_IDX_FLAGS_A: rd_clr[7:0]   = 8'hff;
            `DSAI_IDX_FLAGS_B: rd_clr[15:8]  = 8'hff;
            `DSAI_IDX_FLAGS_C: rd_clr[23:16] = 8'hff;
            default:           rd_clr        = '0;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `DSAI_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `DSAI_RESP_OKAY;
         unique case (rd_idx)
            `DSAI_IDX_FLAGS_A: s_axi_rdata <= {24'h000000, flags[7:0]};
            `DSAI_IDX_FLAGS_B: s_axi_rdata <= {24'h000000, flags[15:8]};
            `DSAI_IDX_FLAGS_C: s_axi_rdata <= {24'h000000, flags[23:16]};
            `DSAI_IDX_MASK_A:  s_axi_rdata <= {24'h000000, mask[7:0]};
            `DSAI_IDX_MASK_B:  s_axi_rdata <= {24'h000000, mask[15:8]};
            `DSAI_IDX_MASK_C:  s_axi_rdata <= {24'h000000, mask[23:16]};
            `DSAI_IDX_EDGE:    s_axi_rdata <= {30'h00000000, edge_sel};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `DSAI_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ---------------- checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   feac_declare_a: assert property (
      new_cond |-> $past(feac.valid) && $past(rep_cnt) == 3'h4
                   && $past(feac.code) == $past(last_code))
      else $error("new message declared without five repeats");

   feac_single_a: assert property (new_cond |=> !new_cond)
      else $error("new message condition held too long");

   new_irq_a: assert property (
      flags[`DSAI_NEW_BIT] && mask[`DSAI_NEW_BIT] |=> irq)
      else $error("new message flag did not raise interrupt");

   read_clear_a: assert property (
      rd_go && rd_idx == `DSAI_IDX_FLAGS_A && set_v[7:0] == 8'h00
      |=> flags[7:0] == 8'h00)
      else $error("flag register not cleared by read");

   rise_sel_a: assert property (
      rise_en && $rose(src.lb_a[0]) |=> flags[0])
      else $error("rising edge did not set flag");

   no_edge_a: assert property (
      !rise_en && !fall_en && !flags[16] && !rd_clr[16] |=> !flags[16])
      else $error("flag set with both edges disabled");

   lb_b_set_a: assert property (
      rise_en && $rose(src.lb_b[6]) |=> flags[14])
      else $error("loopback flag not set");

   lb_irq_a: assert property (flags[0] && mask[0] |=> irq)
      else $error("loopback flag did not raise interrupt");

   sef_flag_a: assert property (
      $rose(sef) |=> flags[`DSAI_SEF_BIT] ##1 (mask[`DSAI_SEF_BIT] -> irq))
      else $error("errored frame flag or interrupt missing");

   alarm_fall_a: assert property (
      fall_en && $fell(src.rx_status[7]) |=> flags[23])
      else $error("falling alarm did not set flag");

   irq_idle_a: assert property ((flags & mask) == '0 |=> !irq)
      else $error("interrupt active with no unmasked flag");

   lb_a_set_a: assert property (
      rise_en && $rose(src.lb_a[6]) |=> flags[6])
      else $error("first group loopback flag not set");

   sef_irq_a: assert property (
      flags[`DSAI_SEF_BIT] && mask[`DSAI_SEF_BIT] |=> irq)
      else $error("errored frame flag did not raise interrupt");

   alarm_irq_a: assert property (
      (flags[23:16] & mask[23:16]) != 8'h00 |=> irq)
      else $error("alarm flag did not raise interrupt");

   irq_any_a: assert property ((flags & mask) != '0 |=> irq)
      else $error("interrupt idle with an unmasked flag");

   set_wins_a: assert property (set_v[0] |=> flags[0])
      else $error("clear overrode a new event");

   write_clear_a: assert property (
      wr_go && s_axi_wstrb[0] && wr_idx == `DSAI_IDX_FLAGS_C && s_axi_wdata[1]
      && !set_v[17] |=> !flags[17])
      else $error("flag not cleared by writing one");

   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before accepted");

   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before accepted");

endmodule
`default_nettype wire

// ==== tb/dsai_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsai_regs.svh"

module dsai_host (
   input  wire logic                    aclk,
   output var  logic [`DSAI_ADDR_W-1:0] s_axi_awaddr,
   output var  logic                    s_axi_awvalid,
   input  wire logic                    s_axi_awready,
   output var  logic [31:0]             s_axi_wdata,
   output var  logic [3:0]              s_axi_wstrb,
   output var  logic                    s_axi_wvalid,
   input  wire logic                    s_axi_wready,
   input  wire logic [1:0]              s_axi_bresp,
   input  wire logic                    s_axi_bvalid,
   output var  logic                    s_axi_bready,
   output var  logic [`DSAI_ADDR_W-1:0] s_axi_araddr,
   output var  logic                    s_axi_arvalid,
   input  wire logic                    s_axi_arready,
   input  wire logic                    s_axi_rvalid,
   output var  logic                    s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end

   // released lines carry the inverse so a stale value cannot pass
   task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      // each channel is released at its own ready, in whatever order
      do
      begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready)
         begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (!w_done && s_axi_wready)
         begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~{24'h0, d};
         end
      end
      while (!(aw_done && w_done));
      do @(posedge aclk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // host reads soon after each request
   task automatic rd(input logic [9:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== tb/ds3_alarm_irq_flags_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsai_regs.svh"

module ds3_alarm_irq_flags_test;
   localparam logic [9:0] FA = 10'h09c, FB = 10'h0a0, FC = 10'h0a4;
   localparam logic [9:0] MA = 10'h0c0, MB = 10'h0c4, MC = 10'h0c8, ED = 10'h0fc;
   logic                 aclk = 1'b0;
   logic                 aresetn = 1'b0;
   logic [9:0]           s_axi_awaddr, s_axi_araddr;
   logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                 s_axi_rvalid, s_axi_rready, irq;
   logic [31:0]          s_axi_wdata, s_axi_rdata;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp, r;
   dsai_pkg::dsai_src_t  src = '0;
   dsai_pkg::dsai_feac_t feac = '0;
   dsai_pkg::dsai_fbit_t fbit = '0;
   logic [33:0]          exp_q[$];
   logic [7:0]           v, w;
   int                   err_total = 0, check_count = 0, cyc = 0;

   dsai_irq_flags i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src, .feac, .fbit, .irq);
   dsai_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
      .s_axi_rready);

   always #5 aclk = ~aclk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic rd(input logic [9:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      i_host.rd(a);
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [1:0] e;
      e = (a[9:2] inside {[`DSAI_IDX_FLAGS_A:`DSAI_IDX_FLAGS_C],
           [`DSAI_IDX_MASK_A:`DSAI_IDX_MASK_C], `DSAI_IDX_EDGE})
          ? `DSAI_RESP_OKAY : `DSAI_RESP_SLVERR;
      i_host.wr(a, d, r);
      check({32'h0, r}, {32'h0, e});
   endtask

   task automatic set_src(input int g, input logic [7:0] d);
      @(posedge aclk);
      case (g)
         0: src.lb_a <= d[6:0];
         1: src.lb_b <= d[6:0];
         default: src.rx_status <= d;
      endcase
      repeat (3) @(posedge aclk);
   endtask

   // errors fall on the last e bits of the burst
   task automatic fb(input int n, input int e, input logic inf);
      for (int i = 0; i < n; i++)
      begin
         @(posedge aclk);
         fbit <= '{1'b1, i >= n - e, inf};
      end
      @(posedge aclk);
      fbit <= '0;
      repeat (3) @(posedge aclk);
   endtask

   task automatic msg(input logic [5:0] c, input int n);
      repeat (n)
      begin
         @(posedge aclk);
         feac <= '{1'b1, c};
      end
      @(posedge aclk);
      feac <= '0;
      repeat (3) @(posedge aclk);
   endtask

   always @(posedge aclk)
   begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         complete_run();
      end
   end

   initial
   begin
      void'($urandom(32'h0880));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int g = 0; g < 3; g++)
         rd(FA + 10'(4 * g), 34'h0);
      rd(MA, 34'h0);
      rd(MB, 34'h0);
      rd(MC, 34'h0);
      rd(ED, 34'h2);
      rd(10'h000, {`DSAI_RESP_SLVERR, 32'h0});
      wr(10'h000, 8'hff);
      for (int g = 0; g < 3; g++)
         for (int m = 0; m < 4; m++)
         begin
            wr(ED, 8'(m));
            // top bits forced so every group sees edges on its end bits
            v = 8'($urandom) | 8'hc1;
            w = (g < 2) ? {1'b0, v[6:0]} : v;
            set_src(g, v);
            rd(FA + 10'(4 * g), m[1] ? {26'h0, w} : 34'h0);
            set_src(g, 8'h00);
            rd(FA + 10'(4 * g), m[0] ? {26'h0, w} : 34'h0);
         end
      wr(ED, 8'h02);
      wr(MA, 8'h81);
      wr(MC, 8'h01);
      rd(MA, 34'h81);
      set_src(1, 8'h01);
      check({33'h0, irq}, 34'h0);
      rd(FB, 34'h01);
      set_src(0, 8'h01);
      set_src(2, 8'h01);
      check({33'h0, irq}, 34'h1);
      rd(FA, 34'h01);
      repeat (2) @(posedge aclk);
      check({33'h0, irq}, 34'h1);
      rd(FC, 34'h01);
      repeat (2) @(posedge aclk);
      check({33'h0, irq}, 34'h0);
      // a second alarm bit, cleared by writing a one instead of a read
      set_src(2, 8'h03);
      wr(FC, 8'h02);
      rd(FC, 34'h0);
      msg(6'h2a, 4);
      msg(6'h15, 1);
      rd(FA, 34'h0);
      msg(6'h15, 7);
      check({33'h0, irq}, 34'h1);
      rd(FA, 34'h80);
      msg(6'h15, 3);
      rd(FA, 34'h0);
      wr(ED, 8'h01);
      wr(MB, 8'h80);
      fb(16, 2, 1'b1);
      rd(FB, 34'h0);
      fb(1, 1, 1'b1);
      // the lead trails the detector by two edges; let it settle
      repeat (2) @(posedge aclk);
      check({33'h0, irq}, 34'h1);
      rd(FB, 34'h80);
      fb(16, 0, 1'b0);
      fb(3, 3, 1'b0);
      rd(FB, 34'h0);
      fb(16, 0, 1'b1);
      rd(FB, 34'h0);
      fb(3, 3, 1'b1);
      rd(FB, 34'h80);
      repeat (2) @(posedge aclk);
      check({33'h0, irq}, 34'h0);
      complete_run();
   end
endmodule
`default_nettype wire
